/* File: logic/onchip_mem_defines.svh */
`ifndef ONCHIP_MEM_DEFINES_SVH
`define ONCHIP_MEM_DEFINES_SVH

// Read-only array window
`define ROM_BASE 32'h0000_0000
`define ROM_LAST 32'h0001_FFFF
`define ROM_IDX_W 15

// RAM window, 8 kbytes
`define RAM_BASE 32'hFFFF_E000
`define RAM_LAST 32'hFFFF_FFFF
`define RAM_IDX_W 11
`define RAM_WORDS 2048

// Flash control register hole
`define FLREG_BASE 32'hFFFF_A800
`define FLREG_LAST 32'hFFFF_A80F
`define UNDEF_READ 32'h0000_0000

// Modes in which the read-only array exists
`define ROM_MODE_A 4'h2
`define ROM_MODE_B 4'h3

// Byte offset width inside a word
`define OFF_W 2

`endif

/* File: logic/onchip_mem_pkg.sv */
package onchip_mem_pkg;

    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_RSVD} access_size_e;

    typedef enum logic [1:0] {REQ_CPU, REQ_XFER, REQ_TRACE, REQ_RSVD} requester_e;

    typedef enum logic [1:0] {TGT_NONE, TGT_ROM, TGT_RAM, TGT_FLREG} target_e;

endpackage

/* File: logic/onchip_ram_array.sv */
`timescale 1ns/10ps
`include "onchip_mem_defines.svh"

module onchip_ram_array
(
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [3:0] be_i,
    input wire logic [`RAM_IDX_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [`RAM_WORDS];

    // No reset on the array: contents held through reset, sleep and standby
    always_ff @(posedge clk_i)
    begin
        if (en_i && we_i)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (be_i[b])
                begin
                    mem[addr_i][8*b +: 8] <= wdata_i[8*b +: 8];
                end
            end
        end
        if (en_i && !we_i)
        begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule // onchip_ram_array

/* File: logic/onchip_mem_access.sv */
// Overview of operation
// - The read-only array answers at byte addresses 0 up to the end of the first 128 kbytes.
// - The read-only array serves byte, halfword and word reads from processor and transfer controller.
// - Each read-only array read is answered one cycle after it is taken, with no wait.
// - The read-only array exists only when the mode pins select mode 2 or 3.
// - The read-only array works after reset and its standby input blocks every access.
// - Reads of the flash control register hole return a fixed filler, not register contents.
// - The RAM serves byte, halfword and word reads and writes from all three requesters.
// - Each RAM read or write is answered one cycle after it is taken, with no wait.
// - RAM contents are kept unchanged through sleep and software standby.
// - With the RAM enable bit clear the RAM does not respond to accesses.
// - The RAM works after reset and its standby input blocks every access.
`timescale 1ns/10ps
`include "onchip_mem_defines.svh"

module onchip_mem_access
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic [3:0] MODE_SEL_I,
    input wire logic ROM_STANDBY_I,
    input wire logic RAM_STANDBY_I,
    input wire logic RAM_ENABLE_I,
    input wire logic SW_STANDBY_I,
    input wire logic REQ_I,
    input wire onchip_mem_pkg::requester_e REQ_SRC_I,
    input wire logic REQ_WRITE_I,
    input wire onchip_mem_pkg::access_size_e REQ_SIZE_I,
    input wire logic [31:0] REQ_ADDR_I,
    input wire logic [31:0] REQ_WDATA_I,
    output logic ACK_O,
    output logic ERR_O,
    output logic [31:0] RDATA_O,
    output logic ROM_PRESENT_O
);
    import onchip_mem_pkg::*;

    function automatic logic is_aligned(access_size_e sz, logic [`OFF_W-1:0] off);
        case (sz)
            SIZE_BYTE: is_aligned = 1'b1;
            SIZE_HALF: is_aligned = !off[0];
            SIZE_WORD: is_aligned = (off == 2'b00);
            default: is_aligned = 1'b0;
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(access_size_e sz, logic [`OFF_W-1:0] off);
        case (sz)
            SIZE_BYTE: lane_mask = 4'h1 << off;
            SIZE_HALF: lane_mask = off[1] ? 4'hC : 4'h3;
            default: lane_mask = 4'hF;
        endcase
    endfunction

    function automatic logic [31:0] extract(logic [31:0] w, access_size_e sz,
                                            logic [`OFF_W-1:0] off);
        logic [31:0] sh;
        sh = w >> {off, 3'b000};
        case (sz)
            SIZE_BYTE: extract = {24'h00_0000, sh[7:0]};
            SIZE_HALF: extract = {16'h0000, sh[15:0]};
            default: extract = sh;
        endcase
    endfunction

    // Fixed mask contents: a pattern derived from the word index
    function automatic logic [31:0] rom_word(logic [`ROM_IDX_W-1:0] idx);
        rom_word = {1'b0, idx, 1'b1, ~idx};
    endfunction

    logic ack;
    logic err;
    target_e sel;
    logic was_write;
    logic [`OFF_W-1:0] off_q;
    access_size_e size_q;
    logic [31:0] rom_q;
    logic [31:0] ram_q;

    wire logic [`OFF_W-1:0] off = REQ_ADDR_I[1:0];
    wire logic [`ROM_IDX_W-1:0] rom_idx = REQ_ADDR_I[`ROM_IDX_W+1:2];
    wire logic [`RAM_IDX_W-1:0] ram_idx = REQ_ADDR_I[`RAM_IDX_W+1:2];

    // Address decode of the three windows
    wire logic in_rom = (REQ_ADDR_I <= `ROM_LAST);
    wire logic in_ram = (REQ_ADDR_I >= `RAM_BASE);
    wire logic in_flreg = (REQ_ADDR_I >= `FLREG_BASE) && (REQ_ADDR_I <= `FLREG_LAST);

    wire logic rom_present = (MODE_SEL_I == `ROM_MODE_A) || (MODE_SEL_I == `ROM_MODE_B);
    wire logic take = REQ_I && !SW_STANDBY_I;
    wire logic aligned = is_aligned(REQ_SIZE_I, off);

    // Read-only array: reads only, processor and transfer controller only
    wire logic rom_src_ok = (REQ_SRC_I == REQ_CPU) || (REQ_SRC_I == REQ_XFER);
    wire logic rom_ok = rom_present && !ROM_STANDBY_I && !REQ_WRITE_I
                        && rom_src_ok;
    wire logic ram_ok = RAM_ENABLE_I && !RAM_STANDBY_I;

    wire logic rom_hit = take && in_rom && rom_ok && aligned;
    wire logic ram_hit = take && in_ram && ram_ok && aligned && (REQ_SRC_I != REQ_RSVD);
    wire logic fl_hit = take && in_flreg && !REQ_WRITE_I && aligned;
    wire logic bad = take && !(rom_hit || ram_hit || fl_hit);

    // Blocked accesses never enable the array
    wire logic ram_en = ram_hit;
    wire logic ram_we = ram_hit && REQ_WRITE_I;
    wire logic [3:0] ram_be = lane_mask(REQ_SIZE_I, off);
    wire logic [31:0] ram_wdata = (REQ_SIZE_I == SIZE_BYTE) ? {4{REQ_WDATA_I[7:0]}} :
                                  (REQ_SIZE_I == SIZE_HALF) ? {2{REQ_WDATA_I[15:0]}} :
                                  REQ_WDATA_I;

    wire target_e next_sel = rom_hit ? TGT_ROM :
                             ram_hit ? TGT_RAM :
                             fl_hit ? TGT_FLREG : TGT_NONE;

    onchip_ram_array u_ram
    (
        .clk_i(SYS_CLK_I),
        .en_i(ram_en),
        .we_i(ram_we),
        .be_i(ram_be),
        .addr_i(ram_idx),
        .wdata_i(ram_wdata),
        .rdata_o(ram_q)
    );

    // Answer one cycle after the request edge, no wait states
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            ack <= 1'b0;
            err <= 1'b0;
            sel <= TGT_NONE;
            was_write <= 1'b0;
            off_q <= 2'b00;
            size_q <= SIZE_WORD;
        end
        else
        begin
            ack <= take;
            err <= bad;
            sel <= next_sel;
            was_write <= REQ_WRITE_I;
            off_q <= off;
            size_q <= REQ_SIZE_I;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            rom_q <= 32'h0000_0000;
        end
        else if (rom_hit)
        begin
            rom_q <= rom_word(rom_idx);
        end
    end

    // Flash register hole reads as filler
    wire logic [31:0] rd_word = (sel == TGT_ROM) ? rom_q :
                                (sel == TGT_RAM) ? ram_q : `UNDEF_READ;
    wire logic rd_valid = (sel != TGT_NONE) && !was_write;

    assign ACK_O = ack;
    assign ERR_O = err;
    assign RDATA_O = rd_valid ? extract(rd_word, size_q, off_q) : 32'h0000_0000;
    assign ROM_PRESENT_O = rom_present;

    chk_rom_single: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        rom_hit |=> ACK_O && !ERR_O)
        else $error("rom read not answered in one cycle");

    chk_ram_single: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        ram_hit |=> ACK_O && !ERR_O)
        else $error("ram access not answered in one cycle");

    chk_rom_word_data: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        rom_hit && REQ_SIZE_I == SIZE_WORD |=> RDATA_O == rom_word($past(rom_idx)))
        else $error("rom word data wrong");

    chk_rom_mode_gate: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        take && in_rom && !rom_present |=> ERR_O && RDATA_O == 32'h0000_0000)
        else $error("rom answered outside modes 2 and 3");

    chk_rom_standby: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        take && in_rom && ROM_STANDBY_I |=> ERR_O)
        else $error("rom answered in standby");

    chk_trace_rom: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        take && in_rom && (REQ_SRC_I == REQ_TRACE || REQ_SRC_I == REQ_RSVD) |=> ERR_O)
        else $error("trace debugger reached rom");

    chk_ram_disabled: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        take && in_ram && !RAM_ENABLE_I |-> !ram_en ##1 ERR_O)
        else $error("disabled ram responded");

    chk_ram_standby: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        take && in_ram && RAM_STANDBY_I |-> !ram_we ##1 ERR_O)
        else $error("ram accessed in standby");

    chk_no_stray_enable: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        ram_en |-> RAM_ENABLE_I && !RAM_STANDBY_I && REQ_I && !SW_STANDBY_I
        && REQ_ADDR_I >= `RAM_BASE)
        else $error("ram enabled without a legal access");

    chk_swsb_quiet: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        REQ_I && SW_STANDBY_I |-> !ram_we ##1 !ACK_O && !ERR_O)
        else $error("request taken in software standby");

    chk_flreg_filler: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        fl_hit |=> ACK_O && !ERR_O && RDATA_O == `UNDEF_READ)
        else $error("flash register hole returned data");

    chk_ram_readback: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        ram_we && REQ_SIZE_I == SIZE_WORD ##1 ram_hit && !REQ_WRITE_I
        && REQ_SIZE_I == SIZE_WORD && ram_idx == $past(ram_idx)
        |=> RDATA_O == $past(REQ_WDATA_I, 2))
        else $error("ram word readback wrong");

endmodule // onchip_mem_access

/* File: tb/bus_requester.sv */
`timescale 1ns/10ps
module bus_requester
(
    output logic req_o,
    output onchip_mem_pkg::requester_e src_o,
    output logic wr_o,
    output onchip_mem_pkg::access_size_e size_o,
    output logic [31:0] addr_o,
    output logic [31:0] wdata_o
);
    import onchip_mem_pkg::*;
    initial
    begin
        req_o = 1'b0;
        src_o = REQ_CPU;
        wr_o = 1'b0;
        size_o = SIZE_WORD;
        addr_o = 32'h0;
        wdata_o = 32'h0;
    end
    // Called just after a rising edge; holds for the taking edge
    task automatic issue(input requester_e s, input logic w, input access_size_e z,
        input logic [31:0] a, input logic [31:0] d);
        req_o <= 1'b1;
        src_o <= s;
        wr_o <= w;
        size_o <= z;
        addr_o <= a;
        wdata_o <= d;
    endtask
    // Idle: write, address and data are scrambled; source and size are held
    task automatic release_bus();
        req_o <= 1'b0;
        wr_o <= ~wr_o;
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
    endtask
endmodule // bus_requester

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`include "onchip_mem_defines.svh"
module testbench;
    import onchip_mem_pkg::*;
    logic clk, rst, rom_sb, ram_sb, ram_en, sws, req, wr, ack, err, present;
    logic [3:0] mode;
    requester_e src;
    access_size_e size;
    logic [31:0] addr, wdata, rdata, a, r, r2;
    logic [31:0] ram_m [0:63];
    logic [64:0] q[$];
    logic [64:0] ex;
    int failures, n_compared, cyc, seed;
    onchip_mem_access onchip_mem_access_i (.SYS_CLK_I(clk), .RESET_I(rst), .MODE_SEL_I(mode),
        .ROM_STANDBY_I(rom_sb), .RAM_STANDBY_I(ram_sb), .RAM_ENABLE_I(ram_en),
        .SW_STANDBY_I(sws), .REQ_I(req), .REQ_SRC_I(src), .REQ_WRITE_I(wr),
        .REQ_SIZE_I(size), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .ACK_O(ack),
        .ERR_O(err), .RDATA_O(rdata), .ROM_PRESENT_O(present));
    bus_requester bus_requester_i (.req_o(req), .src_o(src), .wr_o(wr), .size_o(size),
        .addr_o(addr), .wdata_o(wdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Model the answer, note it, then hand the request to the requester
    task automatic go(input requester_e s, input logic w, input access_size_e z,
        input logic [31:0] a, input logic [31:0] d);
        logic rom, ram, e;
        logic [3:0] be;
        logic [31:0] wd, ws;
        @(posedge clk);
        rom = a <= `ROM_LAST;
        ram = a >= `RAM_BASE;
        be = z == SIZE_BYTE ? 4'h1 << a[1:0] : z == SIZE_HALF ? 4'h3 << a[1:0] : 4'hF;
        if (z == SIZE_RSVD || (z == SIZE_HALF && a[0]) || (z == SIZE_WORD && a[1:0] != 2'h0))
            e = 1'b1;
        else if (rom)
            e = !(mode == `ROM_MODE_A || mode == `ROM_MODE_B) || rom_sb || w || s[1];
        else if (ram)
            e = !ram_en || ram_sb || s == REQ_RSVD;
        else
            e = w || a < `FLREG_BASE || a > `FLREG_LAST;
        wd = rom ? {1'b0, a[16:2], 1'b1, ~a[16:2]} : ram ? ram_m[a[7:2]] : `UNDEF_READ;
        ws = d << (8 * a[1:0]);
        for (int i = 0; i < 4; i++)
            if (!e && !sws && w && ram && be[i]) ram_m[a[7:2]][8*i +: 8] = ws[8*i +: 8];
        wd = wd >> (8 * a[1:0]);
        wd = z == SIZE_BYTE ? wd & 32'hFF : z == SIZE_HALF ? wd & 32'hFFFF : wd;
        if (!sws) q.push_back({cyc + 2, e, (e || w) ? 32'h0 : wd});
        bus_requester_i.issue(s, w, z, a, d);
    endtask
    always @(negedge clk)
        if (ack !== 1'b0 || err !== 1'b0)
        begin
            if (q.size() == 0)
                chk({ack, err}, 2'h0);
            else
            begin
                ex = q.pop_front();
                chk(cyc, ex[64:33]);
                chk({ack, err}, {1'b1, ex[32]});
                chk(rdata, ex[31:0]);
            end
        end
        else
            chk(rdata, 32'h0);
    initial
    begin
        seed = 32'hc16a;
        {rst, mode, rom_sb, ram_sb, ram_en, sws} = {1'b1, 4'h2, 4'h2};
        {failures, n_compared, cyc} = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int m = 0; m < 16; m++)
        begin
            @(posedge clk) mode <= m[3:0];
            @(negedge clk) chk(present, m == 2 || m == 3);
        end
        @(posedge clk) mode <= 4'h2;
        for (int i = 0; i < 64; i++)
        begin
            go(requester_e'(i % 3), 1'b1, SIZE_WORD, `RAM_BASE + 4 * i, $random(seed));
            go(requester_e'(i % 3), 1'b0, SIZE_WORD, `RAM_BASE + 4 * i, 32'h0000_0000);
        end
        for (int i = 0; i < 800; i++)
        begin
            r = $random(seed);
            r2 = $random(seed);
            if (i % 40 == 0)
            begin
                @(posedge clk);
                bus_requester_i.release_bus();
                mode <= {2'h0, r[1:0]};
                {rom_sb, ram_sb} <= {r[3:2] == 2'h0, r[5:4] == 2'h0};
                {ram_en, sws} <= {r[7:6] != 2'h0, r[10:8] == 3'h0};
            end
            case (r[13:12])
                2'h0: a = {15'h0, r2[16:0]};
                2'h1: a = `RAM_BASE + r2[7:0];
                2'h2: a = `FLREG_BASE + r2[3:0];
                default: a = r2[0] ? 32'h0002_0000 : 32'hFFFF_DFFC;
            endcase
            if (r[14]) a[1:0] = 2'h0;
            if (r[15])
            begin
                @(posedge clk);
                bus_requester_i.release_bus();
            end
            go(requester_e'(r[17:16]), r[18], access_size_e'(r[20:19]), a, $random(seed));
        end
        @(posedge clk) bus_requester_i.release_bus();
        repeat (3) @(posedge clk);
        chk(q.size(), 0);
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule // testbench
